// >>> src/flash_seq_defs.svh
// Offsets, field positions, reset values and timing counts of the sequencer
// Assumes inclusion by the package and the design file by bare name
`ifndef FLASH_SEQ_DEFS_SVH
`define FLASH_SEQ_DEFS_SVH
// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_PTR 8'h04
`define OFS_DATA 8'h08
`define OFS_STORE 8'h0C
`define OFS_LOAD 8'h10
`define OFS_LOCK 8'h14
// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define BIT_ENABLE 0
`define BIT_BUSY 6
`define BIT_IRQEN 7
`define CMD_BUF_LOAD 5'h01
`define CMD_ERASE 5'h03
`define CMD_WRITE 5'h05
`define CMD_LOCK 5'h09
`define CMD_REENABLE 5'h11
// ----------------------------------------------------------------------
// Pointer fields and read-back addresses
// ----------------------------------------------------------------------
`define WORD_LSB 1
`define WORD_MSB 5
`define PAGE_LSB 6
`define PAGE_MSB 15
`define HALT_FIRST_PAGE 10'h3C0
`define PTR_FUSE_LOW 16'h0000
`define PTR_LOCK 16'h0001
`define PTR_FUSE_EXT 16'h0002
`define PTR_FUSE_HIGH 16'h0003
// ----------------------------------------------------------------------
// Reset values and windows
// ----------------------------------------------------------------------
`define BUF_ERASED 16'hFFFF
`define LOCK_RESET 6'h3F
`define STORE_WINDOW 3'h4
`define LOAD_LAST 3'h2
// ----------------------------------------------------------------------
// Programming time
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 25
`define PROG_MIN_NS 3700000
`define PROG_MAX_NS 4500000
`define PROG_MIN_CYC ((`PROG_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PROG_MAX_CYC (`PROG_MAX_NS / `CLK_PERIOD_NS)
`endif

// >>> src/flash_seq_pkg.sv
// Types shared by the flash self-programming sequencer
// Assumes the constants header sits beside it
package flash_seq_pkg;
`include "flash_seq_defs.svh"
	// Running flash operation
	typedef enum logic [1:0] {OP_IDLE, OP_ERASE, OP_WRITE, OP_LOCK} op_t;
	// Request towards the flash array
	typedef struct packed {
		logic erase;
		logic write;
		logic [9:0] page;
	} flash_op_t;
	// Fuse bytes in read-back form
	typedef struct packed {
		logic [7:0] low;
		logic [7:0] high;
		logic [7:0] ext;
	} fuse_bytes_t;
	// Whole module state
	typedef struct packed {
		logic awHeld;
		logic [7:0] awAddr;
		logic wHeld;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bValid;
		logic bErr;
		logic rValid;
		logic rErr;
		logic [31:0] rData;
		logic [7:0] ctrl;
		logic [15:0] ptr;
		logic [15:0] data;
		logic [2:0] armCnt;
		op_t op;
		logic [17:0] timer;
		logic [9:0] opPage;
		logic opHalt;
		logic secBusy;
		logic [5:0] lockBits;
		logic [5:0] lockPend;
		logic [15:0] bufRd;
		logic [31:0][15:0] buffer;
	} state_t;
endpackage

// >>> src/flash_self_program_sequencer.sv
// Flash self-programming sequencer reached over AXI4-Lite
// Assumes one 40 MHz clock, synchronous inputs, flash array outside
//
// How it works
// [RULE1] Buffer filled before erase or before write
// [RULE2] Erase: command then store within four cycles
// [RULE3] Erase ignores data and non-page pointer bits
// [RULE4] Halting-section target stalls CPU until done
// [RULE5] Buffer load stores data at word field
// [RULE6] Buffer cleared after write, reenable, reset
// [RULE7] Each buffer slot loaded once per clear
// [RULE8] EEPROM write discards loaded buffer data; the code clears it only while no operation runs
// [RULE9] Write: command then store within four cycles
// [RULE10] Write to halting section stalls the CPU
// [RULE11] Ready interrupt high while enable bit clear
// [RULE12] Page operation blocks section reads, sets busy
// [RULE13] Busy flag stays until reenable is written
// [RULE14] Lock program: byte, command, store in four
// [RULE15] Zero bits of bits 5..0 get programmed
// [RULE16] Pointer ignored; flash stays readable during lock
// [RULE17] EEPROM busy rejects commands and fuse reads
// [RULE18] Software polls EEPROM busy before commanding
// [RULE19] Lock read: load within three cycles
// [RULE20] Enable and lock-set clear on completion or timeout
// [RULE21] Pointer selects low, high or extended fuse
// [RULE22] Programmed bits read zero, unprogrammed one
// [RULE23] Pointer splits into word and page; page latched
// [RULE24] Each programming takes 3.7 to 4.5 ms
// [RULE25] Enable bit held until operation finishes
//
// The register offsets and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`include "flash_seq_defs.svh"
module flash_self_program_sequencer import flash_seq_pkg::*; #(
	parameter int PROG_CYCLES = `PROG_MIN_CYC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// AXI4-Lite write channels
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// System status
	input wire logic eepromWriteBusy,
	input wire fuse_bytes_t fuseBytes,
	// Flash array side
	output flash_op_t flashOp,
	input wire logic [4:0] bufReadIdx,
	output logic [15:0] bufReadData,
	// CPU side
	output logic cpuStall,
	output logic sectionReadBlock,
	output logic spmReadyIrq
);
	// ------------------------------------------------------------------
	// Offset decode
	// ------------------------------------------------------------------
	localparam logic [2:0] R_CTRL = 3'h0;
	localparam logic [2:0] R_PTR = 3'h1;
	localparam logic [2:0] R_DATA = 3'h2;
	localparam logic [2:0] R_STORE = 3'h3;
	localparam logic [2:0] R_LOAD = 3'h4;
	localparam logic [2:0] R_LOCK = 3'h5;
	localparam logic [2:0] R_NONE = 3'h7;
	localparam logic [17:0] PROG_CNT = 18'(PROG_CYCLES);

	// Maps a byte address to a register index
	function automatic logic [2:0] regIdx(input logic [7:0] a);
		logic [2:0] idx;
		idx = R_NONE;
		unique case (a)
			`OFS_CTRL: idx = R_CTRL;
			`OFS_PTR: idx = R_PTR;
			`OFS_DATA: idx = R_DATA;
			`OFS_STORE: idx = R_STORE;
			`OFS_LOAD: idx = R_LOAD;
			`OFS_LOCK: idx = R_LOCK;
			default: idx = R_NONE;
		endcase
		return idx;
	endfunction

	state_t state_r; // Registered state
	state_t state_nxt; // Next state
	logic wrFire; // Write address and data both held
	logic [2:0] wrIdx; // Register hit by the write
	logic rdFire; // Read address taken this cycle
	logic [2:0] rdIdx; // Register hit by the read
	logic storeHit; // Store instruction inside its window
	logic loadHit; // Load instruction inside its window
	logic [4:0] cmd; // Pending command pattern
	logic pageOp; // Erase or write running

	// ------------------------------------------------------------------
	// Event decode
	// ------------------------------------------------------------------
	assign cmd = state_r.ctrl[4:0];
	assign wrFire = state_r.awHeld && state_r.wHeld && !state_r.bValid;
	assign wrIdx = regIdx(state_r.awAddr);
	assign rdFire = s_axi_arvalid && !state_r.rValid;
	assign rdIdx = regIdx(s_axi_araddr);
	assign storeHit = wrFire && wrIdx == R_STORE && state_r.armCnt != 3'h0;
	assign loadHit = rdFire && rdIdx == R_LOAD && cmd == `CMD_LOCK &&
		state_r.armCnt >= `LOAD_LAST; // [RULE19]
	assign pageOp = state_r.op == OP_ERASE || state_r.op == OP_WRITE;

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		// Write channel capture, either order
		if (s_axi_awvalid && !state_r.awHeld && !state_r.bValid) begin
			state_nxt.awHeld = 1'b1;
			state_nxt.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !state_r.wHeld && !state_r.bValid) begin
			state_nxt.wHeld = 1'b1;
			state_nxt.wData = s_axi_wdata;
			state_nxt.wStrb = s_axi_wstrb;
		end
		if (state_r.bValid && s_axi_bready) begin
			state_nxt.bValid = 1'b0;
		end
		if (state_r.rValid && s_axi_rready) begin
			state_nxt.rValid = 1'b0;
		end
		// Registered copy of the buffer slot picked by the array
		state_nxt.bufRd = state_r.buffer[bufReadIdx];
		// Command window countdown; expiry drops the command
		if (state_r.armCnt != 3'h0) begin
			state_nxt.armCnt = state_r.armCnt - 3'h1;
			if (state_r.armCnt == 3'h1) begin
				state_nxt.ctrl[4:0] = 5'h00; // [RULE20]
			end
		end
		// Running operation timed by the cycle counter
		if (state_r.op != OP_IDLE) begin
			state_nxt.timer = state_r.timer - 18'h1; // [RULE24]
			if (state_r.timer == 18'h1) begin
				if (state_r.op == OP_WRITE) begin
					state_nxt.buffer = {32{`BUF_ERASED}}; // [RULE6]
				end
				if (state_r.op == OP_LOCK) begin
					// Zero bits program, programmed stays zero
					state_nxt.lockBits = state_r.lockBits &
						state_r.lockPend; // [RULE15]
				end
				state_nxt.ctrl[4:0] = 5'h00; // [RULE25]
				state_nxt.op = OP_IDLE;
			end
		end
		// Register write
		if (wrFire) begin
			state_nxt.awHeld = 1'b0;
			state_nxt.wHeld = 1'b0;
			state_nxt.bValid = 1'b1;
			state_nxt.bErr = wrIdx == R_NONE;
			unique case (wrIdx)
				R_CTRL: begin
					if (state_r.wStrb[0]) begin
						state_nxt.ctrl[`BIT_IRQEN] = state_r.wData[7];
						// Arm only when idle and EEPROM quiet
						if (state_r.wData[`BIT_ENABLE] &&
							!eepromWriteBusy && // [RULE17]
							state_r.op == OP_IDLE &&
							state_r.armCnt == 3'h0) begin
							state_nxt.ctrl[4:0] = state_r.wData[4:0];
							state_nxt.armCnt = `STORE_WINDOW; // [RULE2]
						end
					end
				end
				R_PTR: begin
					if (state_r.wStrb[0]) begin
						state_nxt.ptr[7:0] = state_r.wData[7:0];
					end
					if (state_r.wStrb[1]) begin
						state_nxt.ptr[15:8] = state_r.wData[15:8];
					end
				end
				R_DATA: begin
					if (state_r.wStrb[0]) begin
						state_nxt.data[7:0] = state_r.wData[7:0];
					end
					if (state_r.wStrb[1]) begin
						state_nxt.data[15:8] = state_r.wData[15:8];
					end
				end
				R_STORE: begin
					if (storeHit) begin
						state_nxt.armCnt = 3'h0;
						state_nxt.ctrl[4:0] = 5'h00;
						unique case (cmd)
							`CMD_BUF_LOAD: begin
								// Word field picks the slot
								state_nxt.buffer[state_r.ptr[
									`WORD_MSB:`WORD_LSB]] =
									state_r.data; // [RULE5]
							end
							`CMD_ERASE, `CMD_WRITE: begin
								// Only the page field is latched
								state_nxt.ctrl[4:0] = cmd; // [RULE3]
								state_nxt.op = cmd == `CMD_ERASE ?
									OP_ERASE : OP_WRITE; // [RULE9]
								state_nxt.opPage = state_r.ptr[
									`PAGE_MSB:`PAGE_LSB]; // [RULE23]
								state_nxt.opHalt = state_r.ptr[
									`PAGE_MSB:`PAGE_LSB] >=
									`HALT_FIRST_PAGE; // [RULE10]
								state_nxt.secBusy = 1'b1; // [RULE12]
								state_nxt.timer = PROG_CNT;
							end
							`CMD_LOCK: begin
								// Pointer plays no part here
								state_nxt.ctrl[4:0] = cmd; // [RULE14]
								state_nxt.op = OP_LOCK; // [RULE16]
								state_nxt.lockPend = state_r.data[5:0];
								state_nxt.timer = PROG_CNT;
							end
							`CMD_REENABLE: begin
								state_nxt.secBusy = 1'b0; // [RULE13]
								state_nxt.buffer =
									{32{`BUF_ERASED}}; // [RULE6]
							end
							default: begin
								state_nxt.ctrl[4:0] = 5'h00;
							end
						endcase
					end
				end
				default: begin
					state_nxt.bErr = wrIdx == R_NONE;
				end
			endcase
		end
		// Register read
		if (rdFire) begin
			state_nxt.rValid = 1'b1;
			state_nxt.rErr = rdIdx == R_NONE;
			state_nxt.rData = 32'h00000000;
			unique case (rdIdx)
				R_CTRL: begin
					state_nxt.rData[7:0] = {state_r.ctrl[7],
						state_r.secBusy, 1'b0, state_r.ctrl[4:0]};
				end
				R_PTR: state_nxt.rData[15:0] = state_r.ptr;
				R_DATA: state_nxt.rData[15:0] = state_r.data;
				R_LOCK: state_nxt.rData[7:0] = {2'b11, state_r.lockBits};
				R_LOAD: begin
					// Fuse and lock read, refused while EEPROM busy
					if (loadHit && !eepromWriteBusy) begin // [RULE17]
						unique case (state_r.ptr)
							`PTR_FUSE_LOW: state_nxt.rData[7:0] =
								fuseBytes.low; // [RULE21]
							`PTR_LOCK: state_nxt.rData[7:0] =
								{2'b11, state_r.lockBits}; // [RULE22]
							`PTR_FUSE_EXT: state_nxt.rData[7:0] =
								fuseBytes.ext;
							`PTR_FUSE_HIGH: state_nxt.rData[7:0] =
								fuseBytes.high;
							default: state_nxt.rData[7:0] = 8'hFF;
						endcase
					end
					if (loadHit) begin
						state_nxt.armCnt = 3'h0;
						state_nxt.ctrl[4:0] = 5'h00; // [RULE20]
					end
				end
				default: state_nxt.rData = 32'h00000000;
			endcase
		end
		// EEPROM write while no operation runs throws away any loaded words
		if (eepromWriteBusy && state_r.op == OP_IDLE) begin
			state_nxt.buffer = {32{`BUF_ERASED}}; // [RULE8]
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_r <= '0;
			state_r.op <= OP_IDLE;
			state_r.lockBits <= `LOCK_RESET;
			state_r.lockPend <= `LOCK_RESET;
			state_r.bufRd <= `BUF_ERASED;
			state_r.buffer <= {32{`BUF_ERASED}}; // [RULE6]
		end else begin
			state_r <= state_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign s_axi_awready = !state_r.awHeld && !state_r.bValid;
	assign s_axi_wready = !state_r.wHeld && !state_r.bValid;
	assign s_axi_bvalid = state_r.bValid;
	assign s_axi_bresp = state_r.bErr ? 2'b10 : 2'b00;
	assign s_axi_arready = !state_r.rValid;
	assign s_axi_rvalid = state_r.rValid;
	assign s_axi_rdata = state_r.rData;
	assign s_axi_rresp = state_r.rErr ? 2'b10 : 2'b00;
	assign flashOp.erase = state_r.op == OP_ERASE;
	assign flashOp.write = state_r.op == OP_WRITE;
	assign flashOp.page = state_r.opPage;
	assign bufReadData = state_r.bufRd;
	assign cpuStall = pageOp && state_r.opHalt; // [RULE4]
	assign sectionReadBlock = state_r.secBusy; // [RULE12]
	assign spmReadyIrq = state_r.ctrl[`BIT_IRQEN] &&
		!state_r.ctrl[`BIT_ENABLE]; // [RULE11]

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	property p_windowExpires;
		@(posedge clk_sys) disable iff (!resetn)
		(state_r.armCnt == 3'h1 && !storeHit && !loadHit && !wrFire)
		|=> state_r.ctrl[4:0] == 5'h00;
	endproperty
	a_windowExpires: assert property (p_windowExpires) // [RULE20]
		else $error("command window did not expire");

	property p_eraseStarts;
		@(posedge clk_sys) disable iff (!resetn)
		(storeHit && cmd == `CMD_ERASE)
		|=> state_r.op == OP_ERASE && state_r.secBusy &&
		state_r.opPage == $past(state_r.ptr[15:6]);
	endproperty
	a_eraseStarts: assert property (p_eraseStarts) // [RULE2]
		else $error("erase did not start with latched page");

	property p_busyDuringOp;
		@(posedge clk_sys) disable iff (!resetn)
		pageOp |-> sectionReadBlock && state_r.ctrl[`BIT_ENABLE];
	endproperty
	a_busyDuringOp: assert property (p_busyDuringOp) // [RULE12]
		else $error("section not blocked during page operation");

	property p_stallHalt;
		@(posedge clk_sys) disable iff (!resetn)
		(storeHit && cmd == `CMD_WRITE && state_r.ptr[15:6] <
		`HALT_FIRST_PAGE) |=> !cpuStall [*8];
	endproperty
	a_stallHalt: assert property (p_stallHalt) // [RULE10]
		else $error("stall for concurrent-read target");

	property p_irqLevel;
		@(posedge clk_sys) disable iff (!resetn)
		(state_r.op != OP_IDLE) |-> !spmReadyIrq;
	endproperty
	a_irqLevel: assert property (p_irqLevel) // [RULE11]
		else $error("ready interrupt while operation runs");

	property p_writeClears;
		@(posedge clk_sys) disable iff (!resetn)
		(state_r.op == OP_WRITE && state_r.timer == 18'h1)
		|=> state_r.buffer == {32{`BUF_ERASED}} &&
		spmReadyIrq == state_r.ctrl[`BIT_IRQEN];
	endproperty
	a_writeClears: assert property (p_writeClears) // [RULE6]
		else $error("buffer not cleared after page write");

	property p_eeReject;
		@(posedge clk_sys) disable iff (!resetn)
		(eepromWriteBusy && state_r.armCnt == 3'h0) |=>
		state_r.armCnt == 3'h0;
	endproperty
	a_eeReject: assert property (p_eeReject) // [RULE17]
		else $error("command armed while EEPROM busy");

	property p_lockProgram;
		@(posedge clk_sys) disable iff (!resetn)
		(state_r.op == OP_LOCK && state_r.timer == 18'h1) |=>
		state_r.lockBits == ($past(state_r.lockBits) &
		$past(state_r.lockPend)) &&
		!$changed(state_r.secBusy);
	endproperty
	a_lockProgram: assert property (p_lockProgram) // [RULE15]
		else $error("lock bits not programmed");

	property p_busySticky;
		@(posedge clk_sys) disable iff (!resetn)
		(state_r.secBusy && !(storeHit && cmd == `CMD_REENABLE))
		|=> state_r.secBusy;
	endproperty
	a_busySticky: assert property (p_busySticky) // [RULE13]
		else $error("busy flag dropped without reenable");
endmodule

// >>> bench/boot_cpu_model.sv
// Boot loader CPU model: AXI4-Lite master for the sequencer registers
// Assumes one clock; every task is entered just after a rising edge
`timescale 1ns/1ps
`include "flash_seq_defs.svh"
module boot_cpu_model (
	// Clock and status
	input wire logic clk_sys,
	input wire logic eepromWriteBusy,
	// Write channels
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	// Read channels
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	// ------------------------------------------------------------------
	// Bus tasks
	// ------------------------------------------------------------------
	// Idle bus; response readies held high so no edge toggles them
	initial begin
		awaddr = 8'h00;
		awvalid = 1'b0;
		wdata = 32'h0;
		wstrb = 4'h0;
		wvalid = 1'b0;
		bready = 1'b1;
		araddr = 8'h00;
		arvalid = 1'b0;
		rready = 1'b1;
	end
	// One write: both channels offered, each released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hF;
		wvalid <= 1'b1;
		do begin
			@(posedge clk_sys);
			// Release each channel at its own handshake
			if (awready) begin
				awvalid <= 1'b0;
			end
			if (wready) begin
				wvalid <= 1'b0;
			end
		end while (!bvalid);
	endtask
	// Control write that waits out a running EEPROM write
	task automatic wr_ctrl(input logic [31:0] d);
		while (eepromWriteBusy) @(posedge clk_sys);
		wr(`OFS_CTRL, d);
	endtask
	// One read; data and response taken at the answering edge
	task automatic rd(input logic [7:0] a, output logic [33:0] rsp);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (arready) begin
				arvalid <= 1'b0;
			end
		end while (!rvalid);
		rsp = {rresp, rdata};
	endtask
endmodule

// >>> bench/testbench.sv
// Self-checking bench for the flash self-programming sequencer
// Assumes a shortened programming time and the boot CPU model as master
`timescale 1ns/1ps
`include "flash_seq_defs.svh"
module testbench import flash_seq_pkg::*;;
	localparam int PROG = 20;
	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	logic clk_sys, resetn, eepromWriteBusy;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, cpuStall, sectionReadBlock, spmReadyIrq;
	fuse_bytes_t fuseBytes;
	flash_op_t flashOp;
	logic [4:0] bufReadIdx;
	logic [15:0] bufReadData;
	int error_cnt, num_checks, seed, n;
	logic [33:0] expQ[$];
	logic [33:0] rsp;
	logic [1:0] bExp; // Expected write response
	logic [15:0] vals[4];
	// ------------------------------------------------------------------
	// Instances and clock
	// ------------------------------------------------------------------
	flash_self_program_sequencer #(.PROG_CYCLES(PROG))
		u_flash_self_program_sequencer (.clk_sys, .resetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.eepromWriteBusy, .fuseBytes, .flashOp, .bufReadIdx, .bufReadData,
		.cpuStall, .sectionReadBlock, .spmReadyIrq);
	boot_cpu_model u_boot_cpu_model (.clk_sys, .eepromWriteBusy,
		.awaddr(s_axi_awaddr), .awvalid(s_axi_awvalid),
		.awready(s_axi_awready), .wdata(s_axi_wdata), .wstrb(s_axi_wstrb),
		.wvalid(s_axi_wvalid), .wready(s_axi_wready), .bresp(s_axi_bresp),
		.bvalid(s_axi_bvalid), .bready(s_axi_bready), .araddr(s_axi_araddr),
		.arvalid(s_axi_arvalid), .arready(s_axi_arready),
		.rdata(s_axi_rdata), .rresp(s_axi_rresp), .rvalid(s_axi_rvalid),
		.rready(s_axi_rready));
	// 40 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// ------------------------------------------------------------------
	// Checking
	// ------------------------------------------------------------------
	// Read answers: response and data against the oldest note
	task automatic chk_rd(input logic [33:0] got, input logic [33:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t read got %h exp %h", $time, got, exp);
		end
	endtask
	// Port levels
	task automatic chk_lvl(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t level got %h exp %h", $time, got, exp);
		end
	endtask
	// Watcher takes one note per answered read
	always @(posedge clk_sys) begin
		if (resetn && s_axi_rvalid && s_axi_rready && expQ.size() > 0) begin
			chk_rd({s_axi_rresp, s_axi_rdata}, expQ.pop_front());
		end
		// Every write answer against the response now expected
		if (resetn && s_axi_bvalid && s_axi_bready) begin
			chk_lvl(16'(s_axi_bresp), 16'(bExp));
		end
	end
	// Verdict and end of run
	task automatic report_and_stop();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Watchdog sized well above the whole sequence
	initial begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		$display("ERROR %0t watchdog expired", $time);
		report_and_stop();
	end
	// ------------------------------------------------------------------
	// Stimulus helpers
	// ------------------------------------------------------------------
	// Read with the expected answer noted first
	task automatic rd_exp(input logic [7:0] a, input logic [33:0] e);
		expQ.push_back(e);
		u_boot_cpu_model.rd(a, rsp);
	endtask
	// Pointer, control pattern, then the store inside the window
	task automatic cmd(input logic [15:0] p, input logic [7:0] c);
		u_boot_cpu_model.wr(`OFS_PTR, {16'h0, p});
		u_boot_cpu_model.wr_ctrl({24'h0, c});
		u_boot_cpu_model.wr(`OFS_STORE, 32'h0);
	endtask
	// Buffer slot read through the array port, one cycle behind
	task automatic buf_chk(input logic [4:0] i, input logic [15:0] e);
		bufReadIdx <= i;
		repeat (2) @(posedge clk_sys);
		chk_lvl(bufReadData, e);
	endtask
	// Count cycles of a running erase or write until it ends
	task automatic op_len();
		n = 0;
		while ((flashOp.erase || flashOp.write) && n < 400) begin
			@(posedge clk_sys);
			n++;
		end
	endtask
	// Poll the enable bit until the operation has finished
	task automatic wait_idle();
		for (int k = 0; k < 300; k++) begin
			u_boot_cpu_model.rd(`OFS_CTRL, rsp);
			if (rsp[0] === 1'b0) break;
		end
		chk_lvl(16'(rsp[0]), 16'h0);
	endtask
	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		seed = 32'h419D;
		resetn = 1'b0;
		eepromWriteBusy = 1'b0;
		bufReadIdx = 5'h00;
		fuseBytes = 24'h0;
		error_cnt = 0;
		num_checks = 0;
		bExp = 2'b00;
		repeat (16) @(posedge clk_sys);
		resetn <= 1'b1;
		fuseBytes <= 24'($random(seed));
		@(posedge clk_sys);
		// Reset state and an unmapped address
		rd_exp(`OFS_CTRL, 34'h0);
		rd_exp(8'h18, {2'b10, 32'h0});
		bExp <= 2'b10;
		u_boot_cpu_model.wr(8'h18, 32'h0);
		bExp <= 2'b00;
		rd_exp(`OFS_LOCK, 34'hFF);
		buf_chk(5'h07, `BUF_ERASED);
		$display("test reset done");
		// Fuse and lock read-back for each pointer value
		for (int i = 0; i < 4; i++) begin
			u_boot_cpu_model.wr(`OFS_PTR, i);
			u_boot_cpu_model.wr_ctrl(32'h09);
			rd_exp(`OFS_LOAD, {26'h0, i == 0 ? fuseBytes.low : i == 1 ? 8'hFF :
				i == 2 ? fuseBytes.ext : fuseBytes.high});
			rd_exp(`OFS_CTRL, 34'h0);
		end
		// Window left to expire, then a plain load
		u_boot_cpu_model.wr_ctrl(32'h09);
		repeat (6) @(posedge clk_sys);
		rd_exp(`OFS_LOAD, 34'h0);
		// EEPROM write starts inside an armed window: read, command refused
		u_boot_cpu_model.wr_ctrl(32'h09);
		eepromWriteBusy <= 1'b1;
		rd_exp(`OFS_LOAD, 34'h0);
		u_boot_cpu_model.wr(`OFS_CTRL, 32'h09);
		rd_exp(`OFS_CTRL, 34'h0);
		eepromWriteBusy <= 1'b0;
		$display("test fuse_lock done");
		// One slot loaded, then lost to an EEPROM write
		vals[0] = 16'($random(seed));
		u_boot_cpu_model.wr(`OFS_DATA, {16'h0, vals[0]});
		cmd(16'h0006, 8'h01);
		buf_chk(5'h03, vals[0]);
		eepromWriteBusy <= 1'b1;
		repeat (2) @(posedge clk_sys);
		eepromWriteBusy <= 1'b0;
		buf_chk(5'h03, `BUF_ERASED);
		$display("test buffer_load done");
		// Fill before erase, slots once each and out of order
		for (int i = 0; i < 4; i++) begin
			vals[i] = 16'($random(seed));
			u_boot_cpu_model.wr(`OFS_DATA, {16'h0, vals[i]});
			cmd({10'h3C5, 5'((3 - i) * 9), 1'b0}, 8'h01);
		end
		// Erase of a halting page with stray word bits and interrupt enabled
		u_boot_cpu_model.wr(`OFS_DATA, $random(seed));
		cmd({10'h3C5, 6'h2A}, 8'h83);
		chk_lvl(16'(flashOp), {6'h02, 10'h3C5});
		chk_lvl(16'(cpuStall), 16'h1);
		chk_lvl(16'(sectionReadBlock), 16'h1);
		chk_lvl(16'(spmReadyIrq), 16'h0);
		op_len();
		chk_lvl(16'(n >= PROG - 1 && n <= PROG + 1), 16'h1);
		rd_exp(`OFS_CTRL, 34'hC0);
		chk_lvl(16'(spmReadyIrq), 16'h1);
		chk_lvl(16'(cpuStall), 16'h0);
		buf_chk(5'h09, vals[2]);
		// Write of the same page; pointer moved while it runs
		cmd({10'h3C5, 6'h00}, 8'h05);
		chk_lvl(16'(flashOp), {6'h01, 10'h3C5});
		chk_lvl(16'(cpuStall), 16'h1);
		u_boot_cpu_model.wr(`OFS_PTR, 32'hFFC0);
		chk_lvl(16'(flashOp.page), 16'h3C5);
		wait_idle();
		buf_chk(5'h12, `BUF_ERASED);
		// Write to the concurrent-read section leaves the CPU running
		cmd({10'h005, 6'h00}, 8'h05);
		chk_lvl(16'(cpuStall), 16'h0);
		chk_lvl(16'(sectionReadBlock), 16'h1);
		wait_idle();
		// Re-enable clears the busy flag and the buffer
		u_boot_cpu_model.wr(`OFS_DATA, 32'h1234);
		cmd(16'h0002, 8'h01);
		cmd(16'h0000, 8'h11);
		chk_lvl(16'(sectionReadBlock), 16'h0);
		buf_chk(5'h01, `BUF_ERASED);
		$display("test page_program done");
		// Lock programming, then read-back of the programmed bits
		u_boot_cpu_model.wr(`OFS_DATA, 32'h00F5);
		cmd(16'h0001, 8'h09);
		chk_lvl(16'({cpuStall, sectionReadBlock}), 16'h0);
		wait_idle();
		u_boot_cpu_model.wr(`OFS_PTR, 32'h1);
		u_boot_cpu_model.wr_ctrl(32'h09);
		rd_exp(`OFS_LOAD, 34'hF5);
		rd_exp(`OFS_LOCK, 34'hF5);
		$display("test lock_program done");
		repeat (4) @(posedge clk_sys);
		report_and_stop();
	end
endmodule
